// ==== design/fcpc_checker.v ====
// Flash command protocol checker: sequence tracking and violation flag
`timescale 1ns/10ps
`default_nettype none
`include "fcpc_consts.vh"

module fcpc_checker (
  input  wire       MCLK,
  input  wire       NRST,
  input  wire       ARRAY_WR,
  input  wire       DIV_WR,
  input  wire       CMD_WR,
  input  wire [7:0] CMD_DATA,
  input  wire       OTHER_CTRL_WR,
  input  wire       STAT_WR,
  input  wire       STAT_CBEF_DATA,
  input  wire       STAT_VIOL_DATA,
  input  wire       FROM_DEBUG,
  input  wire       SECURED,
  input  wire       STOP_ENTRY,
  input  wire       ENGINE_DONE,
  output reg        PROTOCOL_VIOLATION_FLAG,
  output reg        COMMAND_BUFFER_EMPTY_FLAG,
  output reg        LAUNCH,
  output reg  [7:0] LAUNCH_CMD,
  output reg        ABORT,
  output reg        BUSY
);

  // ==========================================================
  // Decode helpers
  function is_legal;
    input [7:0] c;
    begin
      is_legal = (c == `FCPC_CMD_BLANK) || (c == `FCPC_CMD_BYTE_PROG) ||
                 (c == `FCPC_CMD_BURST_PROG) || (c == `FCPC_CMD_SECT_ERASE) ||
                 (c == `FCPC_CMD_MASS_ERASE) || (c == `FCPC_CMD_ERASE_ABRT);
    end
  endfunction

  function is_secure_blocked;
    input [7:0] c;
    begin
      is_secure_blocked = (c == `FCPC_CMD_BYTE_PROG) || (c == `FCPC_CMD_BURST_PROG) ||
                          (c == `FCPC_CMD_SECT_ERASE) || (c == `FCPC_CMD_ERASE_ABRT);
    end
  endfunction

  // ==========================================================
  // State
  reg [1:0] state;
  reg [7:0] cmd_held;
  reg       div_set;
  reg       abort_active;
  reg       prog_erase;

  reg [1:0] next_state;
  reg       viol_event;
  reg       do_launch;
  reg       cancel;

  wire launch_req = STAT_WR && STAT_CBEF_DATA;
  wire cbef_zero  = STAT_WR && !STAT_CBEF_DATA;

  // Violation detection and sequence advance
  always @* begin
    next_state = state;
    viol_event = 1'b0;
    do_launch  = 1'b0;
    cancel     = 1'b0;
    if (STOP_ENTRY && BUSY && prog_erase)
      viol_event = 1'b1;
    if (cbef_zero && state != `FCPC_ST_IDLE) begin
      viol_event = 1'b1;
      cancel     = 1'b1;
    end
    if (PROTOCOL_VIOLATION_FLAG) begin
      // Writes do not advance the sequence while the flag stands; a divider write still sets div_set
      next_state = `FCPC_ST_IDLE;
    end else begin
      case (state)
        `FCPC_ST_IDLE: begin
          if (ARRAY_WR) begin
            if (!div_set)
              viol_event = 1'b1;
            else if (abort_active)
              viol_event = 1'b1;
            else if (!COMMAND_BUFFER_EMPTY_FLAG)
              viol_event = 1'b1;
            else
              next_state = `FCPC_ST_ADDR;
          end
        end
        `FCPC_ST_ADDR: begin
          if (ARRAY_WR)
            viol_event = 1'b1;
          else if (OTHER_CTRL_WR || DIV_WR || STAT_WR)
            viol_event = 1'b1;
          else if (CMD_WR) begin
            if (!is_legal(CMD_DATA))
              viol_event = 1'b1;
            else if (FROM_DEBUG && SECURED && is_secure_blocked(CMD_DATA))
              viol_event = 1'b1;
            else
              next_state = `FCPC_ST_CMD;
          end
        end
        `FCPC_ST_CMD: begin
          if (ARRAY_WR)
            viol_event = 1'b1;
          else if (CMD_WR)
            viol_event = 1'b1;
          else if (OTHER_CTRL_WR || DIV_WR)
            viol_event = 1'b1;
          else if (launch_req) begin
            do_launch  = 1'b1;
            next_state = `FCPC_ST_IDLE;
          end
        end
        default: next_state = `FCPC_ST_IDLE;
      endcase
      if (viol_event || cancel)
        next_state = `FCPC_ST_IDLE;
    end
  end

  // Registers
  always @(posedge MCLK) begin
    if (!NRST) begin
      state                     <= `FCPC_ST_IDLE;
      cmd_held                  <= 8'h00;
      div_set                   <= 1'b0;
      abort_active              <= 1'b0;
      prog_erase                <= 1'b0;
      PROTOCOL_VIOLATION_FLAG   <= `FCPC_RST_VIOL;
      COMMAND_BUFFER_EMPTY_FLAG <= `FCPC_RST_CBEF;
      LAUNCH                    <= 1'b0;
      LAUNCH_CMD                <= 8'h00;
      ABORT                     <= 1'b0;
      BUSY                      <= 1'b0;
    end else begin
      state  <= next_state;
      LAUNCH <= do_launch;
      ABORT  <= STOP_ENTRY && BUSY && prog_erase;
      if (DIV_WR)
        div_set <= 1'b1;
      if (CMD_WR && state == `FCPC_ST_ADDR)
        cmd_held <= CMD_DATA;
      // Sticky flag: set wins, zero write has no effect
      if (viol_event)
        PROTOCOL_VIOLATION_FLAG <= 1'b1;
      else if (STAT_WR && STAT_VIOL_DATA)
        PROTOCOL_VIOLATION_FLAG <= 1'b0;
      // Launch, completion and abort tracking
      if (do_launch) begin
        LAUNCH_CMD <= cmd_held;
        BUSY       <= 1'b1;
        prog_erase <= (cmd_held != `FCPC_CMD_BLANK);
        if (cmd_held == `FCPC_CMD_ERASE_ABRT)
          abort_active <= 1'b1;
        else
          COMMAND_BUFFER_EMPTY_FLAG <= 1'b1;
      end else if (ENGINE_DONE || (STOP_ENTRY && BUSY)) begin
        BUSY         <= 1'b0;
        prog_erase   <= 1'b0;
        abort_active <= 1'b0;
        // Buffer frees up once the abort command has run out
        if (abort_active)
          COMMAND_BUFFER_EMPTY_FLAG <= 1'b1;
      end
      // Buffer goes non-empty when the array write is taken
      if (next_state == `FCPC_ST_ADDR && state == `FCPC_ST_IDLE)
        COMMAND_BUFFER_EMPTY_FLAG <= 1'b0;
      else if (cancel || (viol_event && state != `FCPC_ST_IDLE))
        COMMAND_BUFFER_EMPTY_FLAG <= 1'b1;
    end
  end

endmodule // fcpc_checker
`default_nettype wire

// ==== design/fcpc_consts.vh ====
// Constants for the flash command protocol checker
// Notes on behaviour
// - Once the violation flag is set, no further command is processed until a one is written to it.
// - An array write before the clock divider register was written since reset sets the violation flag.
// - An array write while the command buffer empty flag is clear sets the violation flag.
// - A second array write before the pending command is launched sets the violation flag.
// - A second command register write before launch sets the violation flag.
// - After the array write, a write to any control register other than the command register sets the flag.
// - Only codes 0x05, 0x20, 0x25, 0x40, 0x41 and 0x47 are legal; any other code sets the flag.
// - After the command code, only a status write that launches is legal; other control writes set the flag.
// - Entering stop mode while a program or erase runs aborts it and sets the violation flag.
// - While secured, a debug-path write of 0x20, 0x25, 0x40 or 0x47 sets the flag; blank check and mass erase pass.
// - Writing zero to the command buffer empty flag cancels a partial sequence and sets the flag.
// - Launching sector erase abort does not set the command buffer empty flag.
// - Starting a new sequence while a sector erase abort is active sets the flag; software waits for it to end.
`ifndef FCPC_CONSTS_VH
`define FCPC_CONSTS_VH

// ==========================================================
// Command codes
`define FCPC_CMD_BLANK      8'h05
`define FCPC_CMD_BYTE_PROG  8'h20
`define FCPC_CMD_BURST_PROG 8'h25
`define FCPC_CMD_SECT_ERASE 8'h40
`define FCPC_CMD_MASS_ERASE 8'h41
`define FCPC_CMD_ERASE_ABRT 8'h47

// ==========================================================
// Sequence states
`define FCPC_ST_IDLE  2'h0
`define FCPC_ST_ADDR  2'h1
`define FCPC_ST_CMD   2'h2

// ==========================================================
// Reset values
`define FCPC_RST_VIOL 1'b0
`define FCPC_RST_CBEF 1'b1

`endif

// ==== test/fcpc_checker_assertions.sv ====
// Port assertions for the flash command protocol checker
`timescale 1ns/10ps
`default_nettype none
module fcpc_checker_sva (
  input wire logic       MCLK, NRST, ARRAY_WR, CMD_WR, STAT_WR, STAT_CBEF_DATA, STAT_VIOL_DATA,
  input wire logic       FROM_DEBUG, SECURED, STOP_ENTRY, ENGINE_DONE, LAUNCH, ABORT, BUSY,
  input wire logic       PROTOCOL_VIOLATION_FLAG, COMMAND_BUFFER_EMPTY_FLAG,
  input wire logic [7:0] CMD_DATA, LAUNCH_CMD
);
  wire v = PROTOCOL_VIOLATION_FLAG;
  wire e = COMMAND_BUFFER_EMPTY_FLAG;
  // ==========================================================
  // Sequence checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  flag_sticky_a: assert property (v && !(STAT_WR && STAT_VIOL_DATA) |=> v) else $error("flag dropped");
  flag_refuse_a: assert property (v |=> !LAUNCH) else $error("launch while flagged");
  full_buffer_a: assert property (ARRAY_WR && !e |=> v) else $error("busy buffer write passed");
  bad_code_a: assert property (CMD_WR && !(CMD_DATA inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47})
    |=> v) else $error("illegal code passed");
  secure_debug_a: assert property (CMD_WR && FROM_DEBUG && SECURED
    && (CMD_DATA inside {8'h20, 8'h25, 8'h40, 8'h47}) |=> v) else $error("secured code passed");
  abort_empty_a: assert property (LAUNCH && LAUNCH_CMD == 8'h47 |-> !e) else $error("buffer set");
  launch_cause_a: assert property (LAUNCH |-> $past(STAT_WR) && $past(STAT_CBEF_DATA))
    else $error("launch without status write");
  stop_abort_a: assert property (STOP_ENTRY && BUSY && !ENGINE_DONE && !(LAUNCH_CMD inside {8'h05, 8'h47})
    |=> ABORT && v && !BUSY ##1 !ABORT) else $error("stop did not abort");
  cover property (LAUNCH);
  cover property (ABORT);
  cover property ($rose(v));
endmodule // fcpc_checker_sva
bind fcpc_checker fcpc_checker_sva fcpc_checker_sva_inst (.*);
`default_nettype wire

// ==== test/fcpc_checker_tb.sv ====
// Self-checking bench for the flash command protocol checker
`timescale 1ns/10ps
`default_nettype none
module fcpc_checker_tb;
  logic       MCLK = 1'b0, NRST = 1'b0, FROM_DEBUG = 1'b0, SECURED = 1'b0;
  logic [5:0] s = 6'h00;
  logic [7:0] dt = 8'h00;
  logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  int         errors = 0, cmp_count = 0, cyc = 0, i;
  wire        ARRAY_WR = s[0], DIV_WR = s[1], CMD_WR = s[2], OTHER_CTRL_WR = s[3], STAT_WR = s[4];
  wire        STOP_ENTRY = s[5], STAT_CBEF_DATA = dt[0], STAT_VIOL_DATA = dt[1];
  wire [7:0]  CMD_DATA = dt, LAUNCH_CMD;
  wire        PROTOCOL_VIOLATION_FLAG, COMMAND_BUFFER_EMPTY_FLAG, LAUNCH, ABORT, BUSY, ENGINE_DONE;
  fcpc_checker fcpc_checker_inst (.*);
  fcpc_engine_model fcpc_engine_model_inst (.*);
  // ==========================================================
  // Clock and hang limit
  initial forever #10 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      end_sim();
    end
  end
  // ==========================================================
  // Access tasks: one strobe set per cycle, driven at the falling edge
  task automatic op(input logic [5:0] k, input logic [7:0] d);
    @(negedge MCLK);
    s = k;
    dt = d;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go(input logic [7:0] c);
    op(6'h01, 8'h00);
    op(6'h04, c);
    op(6'h10, 8'h01);
    op(6'h00, 8'h00);
  endtask
  task automatic fin();
    for (i = 0; i < 20 && BUSY !== 1'b0; i++) op(6'h00, 8'h00);
    chk(BUSY, 8'h00, "busy");
  endtask
  task automatic bad(input logic [5:0] k1, input logic [7:0] d1, input logic [5:0] k2,
                     input logic [7:0] d2);
    op(6'h01, 8'h00);
    op(k1, d1);
    op(k2, d2);
    op(6'h00, 8'h00);
    chk(PROTOCOL_VIOLATION_FLAG, 8'h01, "flag set");
    op(6'h10, 8'h02);
    op(6'h00, 8'h00);
    chk(PROTOCOL_VIOLATION_FLAG, 8'h00, "flag clear");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    repeat (2) @(negedge MCLK);
    NRST = 1'b1;
    chk(COMMAND_BUFFER_EMPTY_FLAG, 8'h01, "empty after reset");
    go(8'h20);
    chk(PROTOCOL_VIOLATION_FLAG, 8'h01, "no divider");
    chk(LAUNCH, 8'h00, "refused launch");
    op(6'h10, 8'h00);
    op(6'h00, 8'h00);
    chk(PROTOCOL_VIOLATION_FLAG, 8'h01, "zero write");
    bad(6'h00, 8'h00, 6'h02, 8'h00);
    $display("test divider done");
    foreach (codes[j]) begin
      go(codes[j]);
      chk(LAUNCH, 8'h01, "launch");
      chk(LAUNCH_CMD, codes[j], "code");
      fin();
    end
    bad(6'h01, 8'h00, 6'h00, 8'h00);
    bad(6'h04, 8'h20, 6'h04, 8'h20);
    bad(6'h08, 8'h00, 6'h00, 8'h00);
    bad(6'h04, 8'h33, 6'h00, 8'h00);
    bad(6'h04, 8'h20, 6'h08, 8'h00);
    bad(6'h04, 8'h20, 6'h10, 8'h00);
    $display("test sequence errors done");
    SECURED = 1'b1;
    FROM_DEBUG = 1'b1;
    foreach (codes[j]) if (j > 1 && j < 4) bad(6'h04, codes[j], 6'h00, 8'h00);
    bad(6'h04, 8'h20, 6'h00, 8'h00);
    bad(6'h04, 8'h47, 6'h00, 8'h00);
    go(8'h41);
    chk(LAUNCH, 8'h01, "secured erase");
    fin();
    SECURED = 1'b0;
    FROM_DEBUG = 1'b0;
    $display("test secured done");
    go(8'h20);
    op(6'h20, 8'h00);
    op(6'h00, 8'h00);
    chk(ABORT, 8'h01, "abort");
    chk(PROTOCOL_VIOLATION_FLAG, 8'h01, "stop flag");
    bad(6'h00, 8'h00, 6'h00, 8'h00);
    go(8'h47);
    chk(COMMAND_BUFFER_EMPTY_FLAG, 8'h00, "abort empty");
    bad(6'h00, 8'h00, 6'h00, 8'h00);
    fin();
    chk(COMMAND_BUFFER_EMPTY_FLAG, 8'h01, "empty after abort");
    $display("test stop and abort done");
    NRST = 1'b0;
    op(6'h00, 8'h00);
    NRST = 1'b1;
    go(8'h20);
    chk(PROTOCOL_VIOLATION_FLAG, 8'h01, "divider after reset");
    $display("test second reset done");
    end_sim();
  end
endmodule // fcpc_checker_tb
`default_nettype wire

// ==== test/fcpc_engine_model.sv ====
// Flash command engine model that answers launched commands
`timescale 1ns/10ps
`default_nettype none
module fcpc_engine_model (
  input  wire logic MCLK,
  input  wire logic NRST,
  input  wire logic LAUNCH,
  input  wire logic ABORT,
  output wire logic ENGINE_DONE
);
  logic [2:0] cnt = 3'h0;
  // Run time countdown; a stop abort ends the command at once
  always @(posedge MCLK) begin
    if (!NRST || ABORT) cnt <= 3'h0;
    else if (LAUNCH) cnt <= 3'h6;
    else if (cnt != 3'h0) cnt <= cnt - 3'h1;
  end
  assign ENGINE_DONE = (cnt == 3'h1);
endmodule // fcpc_engine_model
`default_nettype wire
